// ### logic/timer_channel_pkg.sv
// Constants, register map and types shared by the timer channel design.
package timer_channel_pkg;

	// ==========================================================
	// Register map (byte offsets).
	localparam logic [7:0] MODE_OFS    = 8'h00;
	localparam logic [7:0] CTRL_OFS    = 8'h04;
	localparam logic [7:0] RELOAD_OFS  = 8'h08;
	localparam logic [7:0] COUNT_OFS   = 8'h0C;
	localparam logic [7:0] CAPTURE_OFS = 8'h10;
	localparam logic [7:0] STATUS_OFS  = 8'h14;
	localparam logic [7:0] MASK_OFS    = 8'h18;
	localparam logic [7:0] ENABLE_OFS  = 8'h1C;

	// ==========================================================
	// Mode register fields.
	localparam int START_IRQ_BIT = 0;
	localparam int MODE_LSB      = 1;
	localparam int EDGE_LSB      = 6;
	localparam int TRIG_LSB      = 8;
	localparam int MASTER_BIT    = 11;
	localparam int CCS_BIT       = 12;
	localparam int CKS_LSB       = 14;
	localparam logic [15:0] MODE_RESET   = 16'h0000;
	localparam logic [15:0] MODE_WR_MASK = 16'hDFCF;
	localparam logic [15:0] EDGE_MASK    = 16'h00C0;

	// ==========================================================
	// Field encodings.
	localparam logic [2:0] MD_INTERVAL = 3'h0;
	localparam logic [2:0] MD_CAPTURE  = 3'h2;
	localparam logic [2:0] MD_EVENT    = 3'h3;
	localparam logic [2:0] MD_ONECOUNT = 3'h4;
	localparam logic [2:0] MD_CAPONE   = 3'h6;
	localparam logic [2:0] TRG_SOFT    = 3'h0;
	localparam logic [2:0] TRG_EDGE    = 3'h1;
	localparam logic [2:0] TRG_BOTH    = 3'h2;
	localparam logic [2:0] TRG_MASTER  = 3'h4;
	localparam logic [1:0] EDG_FALL    = 2'h0;
	localparam logic [1:0] EDG_RISE    = 2'h1;
	localparam logic [1:0] EDG_LOW_W   = 2'h2;
	localparam logic [1:0] EDG_HIGH_W  = 2'h3;

	// ==========================================================
	// Control, status and reset values.
	localparam int START_BIT    = 0;
	localparam int STOP_BIT     = 1;
	localparam int ST_TIMER_BIT = 0;
	localparam int ST_CAPT_BIT  = 1;
	localparam logic [1:0]  STATUS_RESET = 2'h0;
	localparam logic [1:0]  MASK_RESET   = 2'h0;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;

	typedef enum {CH_STOPPED, CH_ARMED, CH_COUNTING} chan_state_t;

endpackage : timer_channel_pkg

// ### logic/count_bus_if.sv
// Signals between the channel control and its counter.
`timescale 1ns/1ps
interface count_bus_if #(parameter int WIDTH = 16);
	logic             load;
	logic [WIDTH-1:0] load_value;
	logic             step;
	logic             up;
	logic [WIDTH-1:0] value;
	logic             zero;

	modport ctrl (output load, load_value, step, up, input value, zero);
	modport cnt  (input load, load_value, step, up, output value, zero);
endinterface : count_bus_if

// ### logic/edge_detect.sv
// Input edge detector clocked by the selected operating clock tick.
`timescale 1ns/1ps
module edge_detect
	import timer_channel_pkg::*;
(
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Sampling.
	input  wire logic       op_tick,
	input  wire logic       timer_input_pin,
	input  wire logic [1:0] input_edge_select,
	input  wire logic [2:0] trigger_source_select,
	// Decoded edges.
	output logic            start_edge,
	output logic            capture_edge,
	output logic            valid_edge
);

	logic pin_q, rise, fall;
	logic next_pin_q, next_rise, next_fall;

	// ==========================================================
	// Sampling: the pin is only looked at on operating clock ticks.
	always_comb
	begin
		next_pin_q = op_tick ? timer_input_pin : pin_q;
		next_rise  = op_tick & timer_input_pin & ~pin_q;
		next_fall  = op_tick & ~timer_input_pin & pin_q;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pin_q <= 1'b0;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end
		else
		begin
			pin_q <= next_pin_q;
			rise  <= next_rise;
			fall  <= next_fall;
		end
	end

	// ==========================================================
	// Edge roles follow the edge select; single-edge trigger uses one.
	always_comb
	begin
		case (input_edge_select)
			EDG_FALL:   start_edge = fall;
			EDG_RISE:   start_edge = rise;
			EDG_LOW_W:  start_edge = fall;
			default:    start_edge = rise;
		endcase
		if (trigger_source_select == TRG_BOTH)
			capture_edge = (input_edge_select == EDG_LOW_W) ? rise :
				(input_edge_select == EDG_HIGH_W) ? fall : start_edge;
		else
			capture_edge = start_edge;
		// A both-edge code makes every pin edge a count edge, so an
		// event count on both edges is not halved.
		valid_edge = input_edge_select[1] ? (rise | fall) : start_edge;
	end

endmodule : edge_detect

// ### logic/channel_counter.sv
// Up/down channel counter with load.
`timescale 1ns/1ps
module channel_counter
	import timer_channel_pkg::*;
(
	// Clock and reset.
	input  wire logic sys_clk,
	input  wire logic rst,
	// Control side.
	count_bus_if.cnt  bus
);

	logic [15:0] next_value;

	// ==========================================================
	// Load has priority over a step in the same cycle.
	always_comb
	begin
		if (bus.load)
			next_value = bus.load_value;
		else if (bus.step)
			next_value = bus.up ? bus.value + 16'h0001
				: bus.value - 16'h0001;
		else
			next_value = bus.value;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			bus.value <= COUNT_RESET;
		else
			bus.value <= next_value;
	end

	assign bus.zero = (bus.value == 16'h0000);

endmodule : channel_counter

// ### logic/timer_channel_mode_control.sv
// One timer channel: mode register, start logic, count clock selection.
`timescale 1ns/1ps
// Functional notes
// - Interval/capture: start raises irq and toggles output only if start_irq_select is 1.
// - Event counter is used with start_irq_select 0 and start gives no irq or toggle.
// - One-count with start_irq_select 0 ignores retriggers while counting, no irq.
// - One-count with start_irq_select 1 reloads and restarts on retrigger, no irq.
// - Capture-and-one-count: no start irq or toggle, retriggers ignored.
// - Interval, event counter and one-count modes count down.
// - Capture and capture-and-one-count modes count up.
// - Only channels 2, 4 and 6 may be set as master.
// - Master bit is fixed 0 on channels 0, 5, 7; channel 0 always acts as master.
// - The count clock drives the counter, the output and the interrupt logic.
// - The operating clock feeds the edge detector; count clock follows the source bit.
// - The third and fourth prescaled clocks are offered only on channels 1 and 3.
// - Trigger source is software, one edge, both edges or master interrupt.
module timer_channel_mode_control
	import timer_channel_pkg::*;
#(
	parameter int CHANNEL_INDEX = 0
)
(
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Register port.
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	// Prescaled operating clock ticks and link to other channels.
	input  wire logic [3:0]  prescale_tick,
	input  wire logic        timer_input_pin,
	input  wire logic        master_irq_in,
	// Channel outputs.
	output logic             timer_out,
	output logic             chan_irq_out,
	output logic             master_channel,
	output logic             channel_enabled_status,
	output logic             irq
);

	// ==========================================================
	// Elaboration check.
	if (CHANNEL_INDEX < 0 || CHANNEL_INDEX > 7)
	begin : g_bad_index
		$error("CHANNEL_INDEX must be 0 to 7");
	end

	localparam bit MASTER_OK = (CHANNEL_INDEX == 2) ||
		(CHANNEL_INDEX == 4) || (CHANNEL_INDEX == 6);
	// Bit 11 also holds the split option on channels 1 and 3.
	localparam bit BIT11_OK = MASTER_OK || (CHANNEL_INDEX == 1) ||
		(CHANNEL_INDEX == 3);
	localparam bit CK_EXTRA_OK = (CHANNEL_INDEX == 1) ||
		(CHANNEL_INDEX == 3);

	// ==========================================================
	// State.
	chan_state_t state, next_state;
	logic [15:0] channel_mode_register, next_mode;
	logic [15:0] reload, next_reload;
	logic [15:0] capture, next_capture;
	logic [1:0]  status, next_status;
	logic [1:0]  mask, next_mask;
	logic        next_timer_out, next_chan_irq;
	logic [15:0] next_rdata;

	// Field views.
	logic       start_irq_select;
	logic [2:0] channel_mode_field;
	logic [1:0] input_edge_select;
	logic [2:0] trigger_source_select;
	logic       count_clock_source;
	logic [1:0] operating_clock_select;
	assign start_irq_select      = channel_mode_register[START_IRQ_BIT];
	assign channel_mode_field    = channel_mode_register[MODE_LSB +: 3];
	assign input_edge_select     = channel_mode_register[EDGE_LSB +: 2];
	assign trigger_source_select = channel_mode_register[TRIG_LSB +: 3];
	assign count_clock_source    = channel_mode_register[CCS_BIT];
	assign operating_clock_select = channel_mode_register[CKS_LSB +: 2];

	// ==========================================================
	// Operating clock: index order of the ticks is 0, 2, 1, 3.
	logic operating_clock;
	always_comb
	begin
		case (operating_clock_select)
			2'h0:    operating_clock = prescale_tick[0];
			2'h1:    operating_clock = prescale_tick[2];
			2'h2:    operating_clock = prescale_tick[1];
			default: operating_clock = prescale_tick[3];
		endcase
	end

	logic start_edge, capture_edge, valid_edge;
	edge_detect u_edge (
		.sys_clk               (sys_clk),
		.rst                   (rst),
		.op_tick               (operating_clock),
		.timer_input_pin       (timer_input_pin),
		.input_edge_select     (input_edge_select),
		.trigger_source_select (trigger_source_select),
		.start_edge            (start_edge),
		.capture_edge          (capture_edge),
		.valid_edge            (valid_edge)
	);

	logic count_clock;
	assign count_clock = count_clock_source ? valid_edge : operating_clock;

	count_bus_if #(.WIDTH(16)) cbus ();
	channel_counter u_counter (
		.sys_clk (sys_clk),
		.rst     (rst),
		.bus     (cbus)
	);

	// ==========================================================
	// Bus decode.
	logic sw_start, sw_stop, status_rd;
	assign sw_start  = wr && addr == CTRL_OFS && wdata[START_BIT];
	assign sw_stop   = wr && addr == CTRL_OFS && wdata[STOP_BIT];
	assign status_rd = rd && addr == STATUS_OFS;

	logic hw_start;
	always_comb
	begin
		case (trigger_source_select)
			TRG_EDGE, TRG_BOTH: hw_start = start_edge;
			TRG_MASTER:         hw_start = master_irq_in;
			default:            hw_start = 1'b0;
		endcase
	end

	logic count_up, capt_mode;
	assign count_up  = channel_mode_field == MD_CAPTURE ||
		channel_mode_field == MD_CAPONE;
	assign capt_mode = count_up;

	// ==========================================================
	// Channel sequencing. Load value follows the count direction.
	logic tim_evt, cap_evt;
	always_comb
	begin
		next_state     = state;
		next_timer_out = timer_out;
		cbus.load       = 1'b0;
		cbus.load_value = count_up ? 16'h0000 : reload;
		cbus.step       = 1'b0;
		cbus.up         = count_up;
		next_capture   = capture;
		tim_evt        = 1'b0;
		cap_evt        = 1'b0;
		if (sw_stop)
			next_state = CH_STOPPED;
		else if (state == CH_STOPPED)
		begin
			if (sw_start)
				next_state = CH_ARMED;
		end
		else if (state == CH_ARMED)
		begin
			if (hw_start || (sw_start &&
				trigger_source_select == TRG_SOFT))
			begin
				next_state = CH_COUNTING;
				cbus.load  = 1'b1;
				if (start_irq_select && (channel_mode_field ==
					MD_INTERVAL || channel_mode_field == MD_CAPTURE))
				begin
					tim_evt        = 1'b1;
					next_timer_out = ~timer_out;
				end
			end
		end
		else
		begin
			if ((hw_start || sw_start) &&
				channel_mode_field == MD_ONECOUNT && start_irq_select)
				cbus.load = 1'b1;
			else if (capt_mode && capture_edge)
			begin
				next_capture = cbus.value;
				cap_evt      = 1'b1;
				cbus.load    = 1'b1;
				if (channel_mode_field == MD_CAPONE)
					next_state = CH_ARMED;
			end
			else if (count_clock)
			begin
				if (!count_up && cbus.zero)
				begin
					tim_evt        = 1'b1;
					next_timer_out = ~timer_out;
					cbus.load      = 1'b1;
					if (channel_mode_field == MD_ONECOUNT)
						next_state = CH_ARMED;
				end
				else
					cbus.step = 1'b1;
			end
		end
	end

	// ==========================================================
	// Registers written by software. Mode writes are held off while
	// enabled except for the edge field, so a stray write cannot
	// change a running mode.
	logic [15:0] mode_wmask;
	always_comb
	begin
		mode_wmask = MODE_WR_MASK;
		if (!BIT11_OK)
			mode_wmask[MASTER_BIT] = 1'b0;
		if (!CK_EXTRA_OK)
			mode_wmask[CKS_LSB] = 1'b0;
		if (state != CH_STOPPED)
			mode_wmask = mode_wmask & EDGE_MASK;
		next_mode   = channel_mode_register;
		next_reload = reload;
		next_mask   = mask;
		if (wr && addr == MODE_OFS)
			next_mode = (wdata & mode_wmask) |
				(channel_mode_register & ~mode_wmask);
		if (wr && addr == RELOAD_OFS)
			next_reload = wdata;
		if (wr && addr == MASK_OFS)
			next_mask = wdata[1:0];
		// Set wins over the read clear.
		next_status = status_rd ? STATUS_RESET : status;
		next_status[ST_TIMER_BIT] = next_status[ST_TIMER_BIT] | tim_evt;
		next_status[ST_CAPT_BIT]  = next_status[ST_CAPT_BIT] | cap_evt;
		next_chan_irq = tim_evt | cap_evt;
	end

	// ==========================================================
	// Read data, valid one cycle after the strobe; unmapped read 0.
	always_comb
	begin
		next_rdata = 16'h0000;
		if (rd)
		begin
			case (addr)
				MODE_OFS:    next_rdata = channel_mode_register;
				RELOAD_OFS:  next_rdata = reload;
				COUNT_OFS:   next_rdata = cbus.value;
				CAPTURE_OFS: next_rdata = capture;
				STATUS_OFS:  next_rdata = {14'h0000, status};
				MASK_OFS:    next_rdata = {14'h0000, mask};
				ENABLE_OFS:  next_rdata = {15'h0000,
					channel_enabled_status};
				default:     next_rdata = 16'h0000;
			endcase
		end
	end

	// ==========================================================
	// State registers.
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state                 <= CH_STOPPED;
			channel_mode_register <= MODE_RESET;
			reload                <= RELOAD_RESET;
			capture               <= COUNT_RESET;
			status                <= STATUS_RESET;
			mask                  <= MASK_RESET;
			timer_out             <= 1'b0;
			chan_irq_out          <= 1'b0;
			rdata                 <= 16'h0000;
		end
		else
		begin
			state                 <= next_state;
			channel_mode_register <= next_mode;
			reload                <= next_reload;
			capture               <= next_capture;
			status                <= next_status;
			mask                  <= next_mask;
			timer_out             <= next_timer_out;
			chan_irq_out          <= next_chan_irq;
			rdata                 <= next_rdata;
		end
	end

	// ==========================================================
	// Status outputs.
	assign channel_enabled_status = (state != CH_STOPPED);
	assign irq = |(status & mask);
	assign master_channel = (CHANNEL_INDEX == 0) ||
		(MASTER_OK && channel_mode_register[MASTER_BIT]);

endmodule : timer_channel_mode_control

// ### sim/timer_channel_mode_control_monitor.sv
// Port-level checker for the timer channel mode control block.
`timescale 1ns/1ps
module timer_channel_mode_control_monitor
	import timer_channel_pkg::*;
#(
	parameter int CHANNEL_INDEX = 0
)
(
	// Clock and reset.
	input wire logic        sys_clk,
	input wire logic        rst,
	// Register port.
	input wire logic [7:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	// Channel outputs.
	input wire logic        timer_out,
	input wire logic        chan_irq_out,
	input wire logic        master_channel,
	input wire logic        channel_enabled_status
);
	// ==========================================================
	// One clock domain, so reset silences every check at once.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_rdata_idle;
		!rd |=> rdata == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside a read answer");

	property p_master_fixed;
		master_channel == (CHANNEL_INDEX == 0) || CHANNEL_INDEX inside {2, 4, 6};
	endproperty
	a_master_fixed: assert property (p_master_fixed)
		else $error("master flag wrong for this channel");

	property p_mode_master;
		rd && addr == MODE_OFS |=>
			!rdata[MASTER_BIT] || !(CHANNEL_INDEX inside {0, 5, 7});
	endproperty
	a_mode_master: assert property (p_mode_master)
		else $error("master bit reads one on a fixed channel");

	property p_mode_clk;
		rd && addr == MODE_OFS |=> !rdata[CKS_LSB] || CHANNEL_INDEX inside {1, 3};
	endproperty
	a_mode_clk: assert property (p_mode_clk)
		else $error("third or fourth clock offered on this channel");

	property p_pulse;
		chan_irq_out |=> !chan_irq_out;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("channel interrupt pulse longer than one cycle");

	// The output only moves on an event, and every event pulses.
	property p_toggle;
		$changed(timer_out) |-> chan_irq_out;
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("timer output changed without an event");

	property p_quiet;
		!channel_enabled_status [*2] |-> !chan_irq_out;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("event from a stopped channel");

	property p_start;
		wr && addr == CTRL_OFS && wdata[START_BIT] && !wdata[STOP_BIT]
			|=> channel_enabled_status;
	endproperty
	a_start: assert property (p_start)
		else $error("start did not enable the channel");

	property p_stop;
		wr && addr == CTRL_OFS && wdata[STOP_BIT] |=> !channel_enabled_status;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop did not disable the channel");
endmodule : timer_channel_mode_control_monitor

bind timer_channel_mode_control timer_channel_mode_control_monitor
	#(.CHANNEL_INDEX(CHANNEL_INDEX)) u_monitor (
	.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .timer_out(timer_out),
	.chan_irq_out(chan_irq_out), .master_channel(master_channel),
	.channel_enabled_status(channel_enabled_status));

// ### sim/timer_channel_mode_control_test.sv
// Self-checking testbench for the timer channel mode control block.
`timescale 1ns/1ps
module timer_channel_mode_control_test
	import timer_channel_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [3:0]  prescale_tick = 4'h0;
	logic        timer_input_pin = 1'b0;
	logic        master_irq_in = 1'b0;
	logic [15:0] rdata;
	logic        timer_out, chan_irq_out, master_channel;
	logic        channel_enabled_status, irq, t0;
	logic        rd_d = 1'b0;
	logic [15:0] m, cnt;
	logic [15:0] np = 16'h0000;
	logic [4:0]  f;
	logic [15:0] exp_q[$];
	int          n_fail = 0, tests_run = 0, cycles = 0;
	int          seed = 32'hA837;
	// Per row: start-irq bit, start pulse, up count, retrigger reload, mask.
	localparam logic [2:0] MDS [8] = '{MD_INTERVAL, MD_INTERVAL, MD_CAPTURE,
		MD_CAPTURE, MD_EVENT, MD_ONECOUNT, MD_ONECOUNT, MD_CAPONE};
	localparam logic [4:0] FLG [8] = '{5'h19, 5'h01, 5'h1C, 5'h05, 5'h01,
		5'h01, 5'h13, 5'h05};

	timer_channel_mode_control #(.CHANNEL_INDEX(0)) DUT (
		.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .prescale_tick(prescale_tick),
		.timer_input_pin(timer_input_pin), .master_irq_in(master_irq_in),
		.timer_out(timer_out), .chan_irq_out(chan_irq_out),
		.master_channel(master_channel),
		.channel_enabled_status(channel_enabled_status), .irq(irq));

	// ==========================================================
	// Clock, 25 ns period.
	initial
	begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task report_and_stop;
		if (n_fail == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	task wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wr_reg

	// The expected word is noted when the read is issued.
	task rd_reg(input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge sys_clk);
		rd <= 1'b0;
	endtask : rd_reg

	// One operating clock tick; unselected ticks carry random noise.
	task tick;
		@(posedge sys_clk) prescale_tick <= {3'($random(seed)), 1'b1};
		@(posedge sys_clk) prescale_tick <= {3'($random(seed)), 1'b0};
		repeat (2) @(posedge sys_clk);
	endtask : tick

	task do_reset;
		@(posedge sys_clk) rst <= 1'b1;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
	endtask : do_reset

	// Read data stands only in the cycle after the strobe.
	always @(negedge sys_clk)
	begin
		if (rd_d)
			check(rdata, exp_q.pop_front());
	end

	// Strobe history, event pulse count and the hang limit.
	always @(posedge sys_clk)
	begin
		rd_d <= rd;
		cycles++;
		if (chan_irq_out === 1'b1)
			np = np + 16'h0001;
		if (cycles == 5000)
		begin
			n_fail++;
			report_and_stop;
		end
	end

	initial
	begin
		do_reset;
		for (int i = 0; i < 9; i++)
			rd_reg(8'(4 * i), 16'h0000);
		check(16'(master_channel), 16'h0001);
		wr_reg(MODE_OFS, 16'hFFFF);
		rd_reg(MODE_OFS, MODE_WR_MASK & ~16'h4800);
		do_reset;
		rd_reg(MODE_OFS, MODE_RESET);
		for (int i = 0; i < 8; i++)
		begin
			f = FLG[i];
			m = {12'h000, MDS[i], f[4]};
			wr_reg(MODE_OFS, m);
			wr_reg(RELOAD_OFS, 16'h0005);
			wr_reg(MASK_OFS, {15'h0000, f[0]});
			np = 16'h0000;
			t0 = timer_out;
			wr_reg(CTRL_OFS, 16'h0001);
			wr_reg(CTRL_OFS, 16'h0001);
			repeat (4) @(posedge sys_clk);
			check(np, {15'h0000, f[3]});
			check(16'(timer_out), {15'h0000, t0 ^ f[3]});
			check(16'(irq), {15'h0000, f[3] & f[0]});
			check(16'(channel_enabled_status), 16'h0001);
			rd_reg(STATUS_OFS, {15'h0000, f[3]});
			rd_reg(STATUS_OFS, 16'h0000);
			cnt = f[2] ? 16'h0000 : 16'h0005;
			rd_reg(COUNT_OFS, cnt);
			tick;
			tick;
			cnt = f[2] ? cnt + 16'h0002 : cnt - 16'h0002;
			rd_reg(COUNT_OFS, cnt);
			// A start while counting is a retrigger.
			wr_reg(CTRL_OFS, 16'h0001);
			repeat (3) @(posedge sys_clk);
			rd_reg(COUNT_OFS, f[1] ? 16'h0005 : cnt);
			rd_reg(STATUS_OFS, 16'h0000);
			check(np, {15'h0000, f[3]});
			wr_reg(MODE_OFS, 16'hFFFF);
			rd_reg(MODE_OFS, m | EDGE_MASK);
			rd_reg(ENABLE_OFS, 16'h0001);
			wr_reg(CTRL_OFS, 16'h0002);
			rd_reg(ENABLE_OFS, 16'h0000);
		end
		// Rising pin edges start a capture run and then capture the
		// count; four count ticks pass between the two edges.
		wr_reg(MODE_OFS, 16'h0144);
		wr_reg(CTRL_OFS, 16'h0001);
		timer_input_pin <= 1'b1;
		tick;
		tick;
		tick;
		timer_input_pin <= 1'b0;
		tick;
		timer_input_pin <= 1'b1;
		tick;
		rd_reg(CAPTURE_OFS, 16'h0004);
		rd_reg(STATUS_OFS, 16'h0002);
		// A master interrupt pulse starts a slave interval run.
		wr_reg(CTRL_OFS, 16'h0002);
		wr_reg(MODE_OFS, 16'h0401);
		wr_reg(CTRL_OFS, 16'h0001);
		np = 16'h0000;
		@(posedge sys_clk) master_irq_in <= 1'b1;
		@(posedge sys_clk) master_irq_in <= 1'b0;
		repeat (2) @(posedge sys_clk);
		check(np, 16'h0001);
		rd_reg(COUNT_OFS, 16'h0005);
		repeat (3) @(posedge sys_clk);
		report_and_stop;
	end
endmodule : timer_channel_mode_control_test
